// >>> dv/rfe_enc_sva.sv
// port checker for the transmit frame encoder
// assumes it is bound to rfe_tx_frame_encoder, one clock domain
`default_nettype none
module rfe_enc_sva #(
    parameter NB_W = 9
) (
    input wire logic            i_core_clk,
    input wire logic            i_arst_n,
    input wire logic [7:0]      i_reg_addr,
    input wire logic            i_reg_wr,
    input wire logic [31:0]     i_reg_wdata,
    input wire logic            i_reg_rd,
    input wire logic [31:0]     o_reg_rdata,
    input wire logic            i_tx_start,
    input wire logic [NB_W-1:0] i_num_bytes,
    input wire logic            o_elem_valid,
    input wire logic            o_elem_is_sym,
    input wire logic [1:0]      o_elem_sym,
    input wire logic            o_elem_bit,
    input wire logic            i_line_ready,
    input wire logic            o_busy,
    input wire logic            o_frame_done,
    input wire logic            o_no_data_err,
    input wire logic            i_auto_detect_en,
    input wire logic            i_md_detect,
    input wire logic [1:0]      i_md_proto,
    input wire logic [2:0]      o_rx_symbol_rate_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    logic [13:0] fr_q;  // shadow of the frame setup word
    logic        go;    // start taken while idle
    logic        empty; // data enabled with nothing to send
    logic [2:0]  bexp;  // baud code the detector should write
    assign go = i_tx_start && !o_busy;
    assign empty = fr_q[10] && (i_num_bytes == '0);
    assign bexp = (i_md_proto < 2'h2) ? 3'h4 : 3'h3 + {1'b0, i_md_proto};
    // track host writes to the frame setup word
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) fr_q <= '0;
        else if (i_reg_wr && i_reg_addr == 8'h18) fr_q <= i_reg_wdata[13:0];
    end
    // start symbol appears two cycles after the start is taken
    sequence s_start_sym;
        ##2 o_elem_valid && o_elem_is_sym && o_elem_sym == fr_q[7:6] - 2'h1;
    endsequence
    sequence s_err_pulse;
        ##1 o_no_data_err ##1 !o_no_data_err;
    endsequence
    a_busy_on_go: assert property (go && !empty |=> o_busy)
        else $error("busy not raised");
    a_start_symbol: assert property (go && !empty && fr_q[7:6] != 2'h0
        |-> s_start_sym)
        else $error("wrong or late start symbol");
    a_err_pulse: assert property (go && empty |-> s_err_pulse)
        else $error("no payload error pulse");
    a_err_no_frame: assert property (o_no_data_err |-> !o_busy)
        else $error("frame beside payload error");
    a_done_ends: assert property (o_frame_done |-> !o_busy && $past(o_busy))
        else $error("frame done without a frame");
    a_baud_detect: assert property (i_auto_detect_en && i_md_detect
        |=> o_rx_symbol_rate_sel == $past(bexp))
        else $error("detector wrote wrong baud code");
    a_baud_read: assert property (i_reg_rd && i_reg_addr == 8'h1a
        |=> o_reg_rdata == {29'h0, $past(o_rx_symbol_rate_sel)})
        else $error("baud read differs from field");
    a_elem_hold: assert property (o_elem_valid && !i_line_ready |=>
        o_elem_valid && $stable({o_elem_is_sym, o_elem_sym, o_elem_bit}))
        else $error("element changed before taken");
endmodule // rfe_enc_sva
bind rfe_tx_frame_encoder rfe_enc_sva #(.NB_W(NB_W)) u_sva (
    .i_core_clk, .i_arst_n, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_reg_rd, .o_reg_rdata, .i_tx_start, .i_num_bytes, .o_elem_valid,
    .o_elem_is_sym, .o_elem_sym, .o_elem_bit, .i_line_ready, .o_busy,
    .o_frame_done, .o_no_data_err, .i_auto_detect_en, .i_md_detect,
    .i_md_proto, .o_rx_symbol_rate_sel);
`default_nettype wire

// >>> dv/rfe_line_model.sv
// line modulator model: takes encoder elements and logs them
// assumes the encoder holds each element until it is taken
`default_nettype none
module rfe_line_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_slow,
    input  wire logic       i_elem_valid,
    input  wire logic       i_elem_is_sym,
    input  wire logic [1:0] i_elem_sym,
    input  wire logic       i_elem_bit,
    output var  logic       o_line_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] got[$];  // taken elements {is_sym, sym, bit}
    // ready every cycle, or every other cycle when slow
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_line_ready <= 1'b0;
        end else begin
            o_line_ready <= i_slow ? !o_line_ready : 1'b1;
            if (i_elem_valid && o_line_ready)
                got.push_back(i_elem_is_sym ? {1'b1, i_elem_sym, 1'b0}
                                            : {3'b000, i_elem_bit});
        end
    end
endmodule // rfe_line_model
`default_nettype wire

// >>> dv/rfe_tx_frame_encoder_bench.sv
// bench for the frame encoder: register, detector and frame tests
// assumes the line model and the bound checker are compiled first
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module rfe_tx_frame_encoder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, start = 0, auto_en = 0;
    logic det = 0, slow = 0, ready, evalid, issym, ebit, busy, done, err;
    logic bready;
    logic [7:0]  addr = 0, bdata;
    logic [31:0] wdata = 0, rdata;
    logic [8:0]  nb = 0;
    logic [1:0]  proto = 0, esym;
    logic [2:0]  rate;
    logic [7:0]  src[4] = '{8'ha5, 8'h3c, 8'hf0, 8'h81}; // payload
    logic [15:0] pre[8] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff,
        16'h0012, 16'he012, 16'h0000, 16'h0000}; // crc start values
    int          bidx = 0, fails = 0, n_compared = 0;
    assign bdata = src[bidx];
    rfe_tx_frame_encoder u_rfe_tx_frame_encoder (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_tx_start(start), .i_num_bytes(nb),
        .i_byte_data(bdata), .i_byte_valid(1'b1), .o_byte_ready(bready),
        .o_elem_valid(evalid), .o_elem_is_sym(issym), .o_elem_sym(esym),
        .o_elem_bit(ebit), .i_line_ready(ready), .o_busy(busy),
        .o_frame_done(done), .o_no_data_err(err),
        .i_auto_detect_en(auto_en), .i_md_detect(det),
        .i_md_proto(proto), .o_rx_symbol_rate_sel(rate));
    rfe_line_model u_rfe_line_model (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_slow(slow),
        .i_elem_valid(evalid), .i_elem_is_sym(issym), .i_elem_sym(esym),
        .i_elem_bit(ebit), .o_line_ready(ready));
    initial forever #12.5 clk = !clk;
    // next payload byte once the encoder takes one
    always @(posedge clk) if (bready) bidx <= bidx + 1;
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // build the expected stream, send one frame, compare the log
    task automatic run_frame(input logic [31:0] fr, cr, input int n);
        logic [3:0]  exp[$];
        logic [15:0] c, poly;
        logic        p, b;
        int          lo, hi, len, t;
        c = (cr[5:3] == 3'h7) ? cr[31:16] : pre[cr[5:3]];
        poly = cr[2] ? 16'h0012 : 16'h8408;
        len = cr[2] ? 5 : 16;
        if (cr[2]) c = c & 16'h001f;
        if (fr[7:6] != 0) exp.push_back({1'b1, fr[7:6] - 2'h1, 1'b0});
        for (int k = 0; k < n && fr[10]; k++) begin
            lo = (k == 0 && fr[2:0] != 0) ? 8 - fr[2:0] : 0;
            hi = (k == n - 1 && fr[5:3] != 0) ? fr[5:3] : 8;
            p = fr[12] ^ (fr[13] && k == n - 1);
            for (int i = lo; i < hi; i++) begin
                b = src[k][i];
                exp.push_back({3'b000, b});
                p ^= b;
                if (!(cr[6] && k == 0)) c = (c >> 1) ^ (c[0] ^ b ? poly : 0);
            end
            if (fr[11]) exp.push_back({3'b000, p});
        end
        for (int i = 0; i < len && fr[10] && cr[0]; i++)
            exp.push_back({3'b000, c[i] ^ cr[1]});
        if (fr[9:8] != 0) exp.push_back({1'b1, fr[9:8], 1'b0});
        wr_reg(8'h18, fr);
        wr_reg(8'h19, cr);
        u_rfe_line_model.got.delete();
        @(posedge clk);
        start <= 1'b1;
        nb <= n[8:0];
        bidx <= 0;
        @(posedge clk);
        start <= 1'b0;
        for (t = 0; t < 2000 && done !== 1'b1; t++)
            @(posedge clk) #1;
        if (done !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: no frame end", $time);
            complete_run();
        end
        // stop symbol may lag done by two edges
        repeat (2) @(posedge clk) #1;
        `CHK(u_rfe_line_model.got.size(), exp.size())
        foreach (exp[i]) `CHK(u_rfe_line_model.got[i], exp[i])
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h18, 32'h0);
        rd_chk(8'h19, 32'h0);
        wr_reg(8'h18, 32'hffffffff);
        wr_reg(8'h19, 32'hffffffff);
        wr_reg(8'h1a, 32'hffffffff);
        wr_reg(8'h20, 32'hffffffff);
        rd_chk(8'h18, 32'h00003fff);
        rd_chk(8'h19, 32'hffff007f);
        rd_chk(8'h1a, 32'h00000007);
        rd_chk(8'h20, 32'h0);
        // detector ignored when off, then each protocol in turn
        for (int q = 0; q < 5; q++) begin
            @(posedge clk);
            auto_en <= (q != 0);
            det <= 1'b1;
            proto <= (q == 0) ? 2'h2 : q[1:0] - 2'h1;
            @(posedge clk);
            det <= 1'b0;
            rd_chk(8'h1a, q ? (q < 3 ? 32'h4 : 32'h2 + q) : 32'h7);
        end
        // data enabled with no bytes: error pulse and no frame
        wr_reg(8'h18, 32'h00000400);
        @(posedge clk);
        start <= 1'b1;
        nb <= 9'h0;
        @(posedge clk);
        start <= 1'b0;
        #1 `CHK({err, busy}, 2'b10)
        slow <= 1'b1;
        run_frame(32'h3f6b, 32'h0000000b, 3);
        slow <= 1'b0;
        run_frame(32'h01c0, 32'h00000001, 2);
        run_frame(32'h0680, 32'h5a3c0079, 2);
        run_frame(32'h0c00, 32'h00000025, 1);
        run_frame(32'h0c00, 32'habcd003d, 1);
        for (int s = 0; s < 7; s++)
            run_frame(32'h0400, {26'h0, s[2:0], 3'h1}, 1);
        complete_run();
    end
endmodule // rfe_tx_frame_encoder_bench
`default_nettype wire

// >>> hdl/rfe_map.vh
// constants for the transmit frame encoder: register offsets, field
// positions, crc presets, polynomials and reset values.
// assumes the includer uses these macros for every field it decodes.
//
// Behaviour
// - parity-type bit picks even or odd parity
// - parity bit appended after every payload byte
// - data enabled with zero bytes flags error
// - payload-enable bit gates sending of data bytes
// - stop selector picks none or symbol 1-3
// - start selector picks none or symbol 0-2
// - last-byte field trims trailing bits, 0 full
// - first-byte field trims leading bits, 0 full
// - sixteen-bit custom crc preset is stored
// - skip option leaves first byte out of crc
// - preset selector loads fixed or custom crc start
// - five-bit crc starts from preset low byte
// - crc type bit selects 16 or 5 bits
// - invert bit sends complemented checksum
// - crc enable appends checksum to frame
// - baud field codes 100 to 111 rates
// - mode detector writes baud field on detect
// - flip option inverts parity of final byte
`ifndef RFE_MAP_VH
`define RFE_MAP_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define RFE_AW              8
`define RFE_OFF_FRAME       8'h18
`define RFE_OFF_CRC         8'h19
`define RFE_OFF_BAUD        8'h1a

// -----------------------------------------------------------------
// tx_frame_setup fields
// -----------------------------------------------------------------
`define RFE_FR_FLIP         13
`define RFE_FR_PTYPE        12
`define RFE_FR_PEN          11
`define RFE_FR_DEN          10
`define RFE_FR_STOP         9:8
`define RFE_FR_START        7:6
`define RFE_FR_LAST         5:3
`define RFE_FR_FIRST        2:0
`define RFE_FR_MASK         32'h0000_3fff

// -----------------------------------------------------------------
// tx_crc_setup fields
// -----------------------------------------------------------------
`define RFE_CR_CUSTOM       31:16
`define RFE_CR_SKIP         6
`define RFE_CR_PSEL         5:3
`define RFE_CR_TYPE         2
`define RFE_CR_INV          1
`define RFE_CR_EN           0
`define RFE_CR_MASK         32'hffff_007f

// -----------------------------------------------------------------
// rx_baud_select fields and codes
// -----------------------------------------------------------------
`define RFE_BD_RATE         2:0
`define RFE_BD_MASK         32'h0000_0007
`define RFE_BAUD_106        3'h4
`define RFE_BAUD_212        3'h5
`define RFE_BAUD_424        3'h6
`define RFE_BAUD_848        3'h7
`define RFE_PROTO_A         2'h0
`define RFE_PROTO_B         2'h1
`define RFE_PROTO_212       2'h2
`define RFE_PROTO_424       2'h3

// -----------------------------------------------------------------
// crc presets and polynomials (lsb-first, reflected form)
// -----------------------------------------------------------------
`define RFE_PRE_0           16'h0000
`define RFE_PRE_1           16'h6363
`define RFE_PRE_2           16'ha671
`define RFE_PRE_3           16'hffff
`define RFE_PRE_4           16'h0012
`define RFE_PRE_5           16'he012
`define RFE_PSEL_CUSTOM     3'h7
`define RFE_POLY16          16'h8408
`define RFE_POLY5           16'h0012
`define RFE_CRC16_LEN       5'h10
`define RFE_CRC5_LEN        5'h05

// -----------------------------------------------------------------
// misc
// -----------------------------------------------------------------
`define RFE_RST32           32'h0000_0000
`define RFE_BITS_FULL       4'h8
`define RFE_BYTE_BITS       4'h8

`endif

// >>> hdl/rfe_tx_frame_encoder.v
// transmit frame encoder with its configuration registers and the
// receive baud-rate field that the mode detector may fill in.
// assumes a same-clock register port, a byte source with valid/ready
// and a line modulator that takes one element per accepted cycle.
`include "rfe_map.vh"
`default_nettype none

module rfe_tx_frame_encoder #(
    parameter NB_W = 9                        // width of byte count
) (
    input  wire              i_core_clk,      // core clock, 40 mhz
    input  wire              i_arst_n,        // async reset, low
    input  wire [`RFE_AW-1:0] i_reg_addr,     // register offset
    input  wire              i_reg_wr,        // write strobe
    input  wire [31:0]       i_reg_wdata,     // write data
    input  wire              i_reg_rd,        // read strobe
    output reg  [31:0]       o_reg_rdata,     // read data, next cycle
    input  wire              i_tx_start,      // start a frame
    input  wire [NB_W-1:0]   i_num_bytes,     // bytes to send
    input  wire [7:0]        i_byte_data,     // payload byte
    input  wire              i_byte_valid,    // payload byte present
    output reg               o_byte_ready,    // payload byte taken
    output reg               o_elem_valid,    // element on line port
    output reg               o_elem_is_sym,   // element is a symbol
    output reg  [1:0]        o_elem_sym,      // symbol number
    output reg               o_elem_bit,      // bit value
    input  wire              i_line_ready,    // modulator takes it
    output reg               o_busy,          // frame in progress
    output reg               o_frame_done,    // pulse at frame end
    output reg               o_no_data_err,   // pulse, missing payload
    input  wire              i_auto_detect_en,// mode detector enabled
    input  wire              i_md_detect,     // protocol recognised
    input  wire [1:0]        i_md_proto,      // recognised protocol
    output reg  [2:0]        o_rx_symbol_rate_sel // receive baud code
);

// -----------------------------------------------------------------
// states, one-hot
// -----------------------------------------------------------------
localparam [6:0] ST_IDLE = 7'h01;  // waiting for start
localparam [6:0] ST_SOS  = 7'h02;  // start symbol
localparam [6:0] ST_LOAD = 7'h04;  // fetch next byte
localparam [6:0] ST_BIT  = 7'h08;  // data bits
localparam [6:0] ST_PAR  = 7'h10;  // parity bit
localparam [6:0] ST_CRC  = 7'h20;  // checksum bits
localparam [6:0] ST_EOS  = 7'h40;  // stop symbol

// -----------------------------------------------------------------
// functions
// -----------------------------------------------------------------
// crc start value from the preset selector
function [15:0] crc_preset;
    input [2:0]  sel;
    input [15:0] custom;
    begin
        case (sel)
            3'h0:             crc_preset = `RFE_PRE_0;
            3'h1:             crc_preset = `RFE_PRE_1;
            3'h2:             crc_preset = `RFE_PRE_2;
            3'h3:             crc_preset = `RFE_PRE_3;
            3'h4:             crc_preset = `RFE_PRE_4;
            3'h5:             crc_preset = `RFE_PRE_5;
            `RFE_PSEL_CUSTOM: crc_preset = custom;
            default:          crc_preset = `RFE_PRE_0; // reserved
        endcase
    end
endfunction

// one lsb-first crc step, 16 or 5 bits wide
function [15:0] crc_step;
    input [15:0] c;
    input        b;
    input        five;
    reg          fb;
    begin
        fb = c[0] ^ b;
        if (five) begin
            crc_step = {12'h000, c[4:1]} ^ (fb ? `RFE_POLY5 : 16'h0000);
        end else begin
            crc_step = {1'b0, c[15:1]} ^ (fb ? `RFE_POLY16 : 16'h0000);
        end
    end
endfunction

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
reg  [13:0]     frame_q;      // tx_frame_setup
reg  [31:0]     crcset_q;     // tx_crc_setup, implemented bits only
reg  [6:0]      st_q;         // state
reg  [NB_W-1:0] left_q;       // bytes still to fetch after current
reg             first_q;      // current byte is the first
reg  [7:0]      byte_q;       // current payload byte
reg  [3:0]      idx_q;        // next bit index
reg  [3:0]      hi_q;         // bit index after the last sent
reg             par_q;        // running xor of sent bits
reg  [15:0]     crc_q;        // checksum register
reg  [4:0]      ccnt_q;       // checksum bits left
reg             crc_loaded_q; // checksum copied for sending

wire       flip_en  = frame_q[`RFE_FR_FLIP];
wire       ptype    = frame_q[`RFE_FR_PTYPE];
wire       par_en   = frame_q[`RFE_FR_PEN];
wire       data_en  = frame_q[`RFE_FR_DEN];
wire [1:0] stop_sel = frame_q[`RFE_FR_STOP];
wire [1:0] strt_sel = frame_q[`RFE_FR_START];
wire [2:0] last_b   = frame_q[`RFE_FR_LAST];
wire [2:0] first_b  = frame_q[`RFE_FR_FIRST];
wire       crc_en   = crcset_q[`RFE_CR_EN];
wire       crc_five = crcset_q[`RFE_CR_TYPE];
wire       is_last  = (left_q == {NB_W{1'b0}});
wire       can_emit = ~o_elem_valid | i_line_ready;
wire       crc_on   = ~(crcset_q[`RFE_CR_SKIP] & first_q);

// -----------------------------------------------------------------
// register port: writes, hardware update of baud field, reads
// -----------------------------------------------------------------
// host writes; mode detector result overrides a same-cycle write
always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        frame_q              <= 14'h0000;
        crcset_q             <= `RFE_RST32;
        o_rx_symbol_rate_sel <= 3'h0;
    end else begin
        if (i_reg_wr && i_reg_addr == `RFE_OFF_FRAME) begin
            frame_q <= i_reg_wdata[13:0];
        end
        if (i_reg_wr && i_reg_addr == `RFE_OFF_CRC) begin
            crcset_q <= i_reg_wdata & `RFE_CR_MASK;
        end
        if (i_auto_detect_en && i_md_detect) begin
            case (i_md_proto)
                `RFE_PROTO_A:   o_rx_symbol_rate_sel <= `RFE_BAUD_106;
                `RFE_PROTO_B:   o_rx_symbol_rate_sel <= `RFE_BAUD_106;
                `RFE_PROTO_212: o_rx_symbol_rate_sel <= `RFE_BAUD_212;
                default:        o_rx_symbol_rate_sel <= `RFE_BAUD_424;
            endcase
        end else if (i_reg_wr && i_reg_addr == `RFE_OFF_BAUD) begin
            o_rx_symbol_rate_sel <= i_reg_wdata[`RFE_BD_RATE];
        end
    end
end

// registered read, unmapped offsets read zero
always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_reg_rdata <= `RFE_RST32;
    end else if (i_reg_rd) begin
        case (i_reg_addr)
            `RFE_OFF_FRAME: o_reg_rdata <= {18'h00000, frame_q};
            `RFE_OFF_CRC:   o_reg_rdata <= crcset_q;
            `RFE_OFF_BAUD:  o_reg_rdata <= {29'h0, o_rx_symbol_rate_sel};
            default:        o_reg_rdata <= `RFE_RST32;
        endcase
    end
end

// -----------------------------------------------------------------
// frame sequencer
// -----------------------------------------------------------------
// walks start symbol, bytes with parity, checksum, stop symbol
always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        st_q          <= ST_IDLE;
        left_q        <= {NB_W{1'b0}};
        first_q       <= 1'b0;
        byte_q        <= 8'h00;
        idx_q         <= 4'h0;
        hi_q          <= 4'h0;
        par_q         <= 1'b0;
        crc_q         <= 16'h0000;
        ccnt_q        <= 5'h00;
        crc_loaded_q  <= 1'b0;
        o_byte_ready  <= 1'b0;
        o_elem_valid  <= 1'b0;
        o_elem_is_sym <= 1'b0;
        o_elem_sym    <= 2'h0;
        o_elem_bit    <= 1'b0;
        o_busy        <= 1'b0;
        o_frame_done  <= 1'b0;
        o_no_data_err <= 1'b0;
    end else begin
        o_frame_done  <= 1'b0;
        o_no_data_err <= 1'b0;
        // drop the element once the modulator took it
        if (o_elem_valid && i_line_ready) begin
            o_elem_valid <= 1'b0;
        end
        case (st_q)
            ST_IDLE: begin
                if (i_tx_start) begin
                    if (data_en && i_num_bytes == {NB_W{1'b0}}) begin
                        o_no_data_err <= 1'b1;
                    end else begin
                        o_busy       <= 1'b1;
                        left_q       <= i_num_bytes - 1'b1;
                        first_q      <= 1'b1;
                        crc_loaded_q <= 1'b0;
                        // five-bit mode keeps the low byte
                        crc_q <= crc_preset(crcset_q[`RFE_CR_PSEL],
                            crcset_q[`RFE_CR_CUSTOM])
                            & (crc_five ? 16'h00ff : 16'hffff);
                        if (strt_sel != 2'h0) begin
                            st_q <= ST_SOS;
                        end else if (data_en) begin
                            st_q         <= ST_LOAD;
                            o_byte_ready <= 1'b1;
                        end else if (stop_sel != 2'h0) begin
                            st_q <= ST_EOS;
                        end else begin
                            st_q         <= ST_IDLE;
                            o_busy       <= 1'b0;
                            o_frame_done <= 1'b1;
                        end
                    end
                end
            end
            ST_SOS: begin
                if (can_emit) begin
                    o_elem_valid  <= 1'b1;
                    o_elem_is_sym <= 1'b1;
                    o_elem_sym    <= strt_sel - 2'h1;
                    if (data_en) begin
                        st_q         <= ST_LOAD;
                        o_byte_ready <= 1'b1;
                    end else begin
                        st_q <= ST_EOS;
                    end
                end
            end
            ST_LOAD: begin
                if (o_byte_ready && i_byte_valid) begin
                    o_byte_ready <= 1'b0;
                    byte_q       <= i_byte_data;
                    par_q        <= 1'b0;
                    // leading bits of the first byte are dropped
                    if (first_q && first_b != 3'h0) begin
                        idx_q <= `RFE_BITS_FULL - {1'b0, first_b};
                    end else begin
                        idx_q <= 4'h0;
                    end
                    // trailing bits of the last byte are dropped
                    if (is_last && last_b != 3'h0) begin
                        hi_q <= {1'b0, last_b};
                    end else begin
                        hi_q <= `RFE_BITS_FULL;
                    end
                    st_q <= ST_BIT;
                end
            end
            ST_BIT: begin
                if (can_emit) begin
                    o_elem_valid  <= 1'b1;
                    o_elem_is_sym <= 1'b0;
                    o_elem_bit    <= byte_q[idx_q[2:0]];
                    par_q         <= par_q ^ byte_q[idx_q[2:0]];
                    if (crc_on) begin
                        crc_q <= crc_step(crc_q, byte_q[idx_q[2:0]],
                                          crc_five);
                    end
                    idx_q <= idx_q + 4'h1;
                    if (idx_q + 4'h1 >= hi_q) begin
                        if (par_en) begin
                            st_q <= ST_PAR;
                        end else if (!is_last) begin
                            st_q         <= ST_LOAD;
                            o_byte_ready <= 1'b1;
                            left_q       <= left_q - 1'b1;
                            first_q      <= 1'b0;
                        end else if (crc_en) begin
                            st_q <= ST_CRC;
                        end else begin
                            st_q <= ST_EOS;
                        end
                    end
                end
            end
            ST_PAR: begin
                if (can_emit) begin
                    o_elem_valid  <= 1'b1;
                    o_elem_is_sym <= 1'b0;
                    // odd flips even parity, final may flip too
                    o_elem_bit    <= par_q ^ ptype ^ (is_last & flip_en);
                    if (!is_last) begin
                        st_q         <= ST_LOAD;
                        o_byte_ready <= 1'b1;
                        left_q       <= left_q - 1'b1;
                        first_q      <= 1'b0;
                    end else if (crc_en) begin
                        st_q <= ST_CRC;
                    end else begin
                        st_q <= ST_EOS;
                    end
                end
            end
            ST_CRC: begin
                if (!crc_loaded_q) begin
                    // width and polarity of the checksum
                    crc_loaded_q <= 1'b1;
                    ccnt_q <= crc_five ? `RFE_CRC5_LEN : `RFE_CRC16_LEN;
                    if (crcset_q[`RFE_CR_INV]) begin
                        crc_q <= ~crc_q;
                    end
                end else if (can_emit) begin
                    o_elem_valid  <= 1'b1;
                    o_elem_is_sym <= 1'b0;
                    o_elem_bit    <= crc_q[0];
                    crc_q         <= {1'b0, crc_q[15:1]};
                    ccnt_q        <= ccnt_q - 5'h01;
                    if (ccnt_q == 5'h01) begin
                        st_q <= ST_EOS;
                    end
                end
            end
            ST_EOS: begin
                if (can_emit) begin
                    if (stop_sel != 2'h0) begin
                        o_elem_valid  <= 1'b1;
                        o_elem_is_sym <= 1'b1;
                        o_elem_sym    <= stop_sel;
                    end
                    st_q         <= ST_IDLE;
                    o_busy       <= 1'b0;
                    o_frame_done <= 1'b1;
                end
            end
            default: begin
                st_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule // rfe_tx_frame_encoder

`default_nettype wire
